// ===== pkg/dcf_pkg.sv
// Shared constants for the FIFO flag block: register map, fields, resets
package dcf_pkg;

  // Storage is counted in bit positions; pointers carry one wrap bit
  localparam int DCF_AW = 12;
  localparam int DCF_PTR_W = DCF_AW + 1;
  localparam int DCF_DEPTH = 4096;
  localparam logic [DCF_PTR_W-1:0] DCF_DEPTH_BITS = 13'h1000;
  localparam int DCF_MAX_W = 16;
  localparam int DCF_THR_W = 12;

  // Width codes: 0..4 select 1, 2, 4, 8, 16 bits; larger codes mean 16
  localparam logic [2:0] DCF_CODE_MAX = 3'h4;

  // AXI4-Lite register map, byte addresses
  localparam int DCF_ADDR_W = 8;
  localparam logic [DCF_ADDR_W-1:0] DCF_OFF_CTRL = 8'h00;
  localparam logic [DCF_ADDR_W-1:0] DCF_OFF_AE_THR = 8'h04;
  localparam logic [DCF_ADDR_W-1:0] DCF_OFF_AF_THR = 8'h08;
  localparam logic [DCF_ADDR_W-1:0] DCF_OFF_STATUS = 8'h0c;
  localparam logic [DCF_ADDR_W-1:0] DCF_OFF_IRQ_STAT = 8'h10;
  localparam logic [DCF_ADDR_W-1:0] DCF_OFF_IRQ_EN = 8'h14;
  localparam logic [DCF_ADDR_W-1:0] DCF_OFF_IRQ_CLR = 8'h18;

  // Control register fields
  localparam int DCF_CTRL_WCODE = 0;
  localparam int DCF_CTRL_RCODE = 4;
  localparam int DCF_CTRL_PIPE = 8;

  // Status register fields
  localparam int DCF_ST_EMPTY = 0;
  localparam int DCF_ST_FULL = 1;
  localparam int DCF_ST_AE = 2;
  localparam int DCF_ST_AF = 3;
  localparam int DCF_ST_LEVEL = 16;

  // Interrupt event bits
  localparam int DCF_EV_W = 4;
  localparam int DCF_EV_WR_REFUSED = 0;
  localparam int DCF_EV_RD_REFUSED = 1;
  localparam int DCF_EV_AE_RISE = 2;
  localparam int DCF_EV_AF_RISE = 3;

  // Reset values
  localparam logic [2:0] DCF_RST_WCODE = 3'h3;
  localparam logic [2:0] DCF_RST_RCODE = 3'h3;
  localparam logic [DCF_THR_W-1:0] DCF_RST_AE_THR = 12'h010;
  localparam logic [DCF_THR_W-1:0] DCF_RST_AF_THR = 12'hff0;

  // AXI responses
  localparam logic [1:0] DCF_RESP_OKAY = 2'h0;
  localparam logic [1:0] DCF_RESP_SLVERR = 2'h2;

endpackage

// ===== design/dcf_fifo_flags.sv
// Single-clock mixed-width FIFO with flag logic and an AXI4-Lite register slave
//
// Behaviour
// - Near-drained set when level at/below threshold
// - Near-drained clears only when level exceeds threshold
// - Near-filled level counts only whole write-side entries
// - Both thresholds are 12-bit bit-position counts
// - Full/empty whenever a whole word cannot move
// - 2-bit write, 4-bit read: empty after one write
// - 4-bit write, 2-bit read: full stays after one read
// - Empty flag updated on the read-side clock edge
// - Full flag updated on the write-side clock edge
// - Reset clears read data and sets flag reset states
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none

module dcf_fifo_flags
  import dcf_pkg::*;
#(
  parameter int DATA_W = DCF_MAX_W
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic write_en,
  input wire logic [DATA_W-1:0] write_data_in,
  input wire logic read_en,
  input wire logic block_select_in,
  output logic [DATA_W-1:0] read_data,
  output logic empty,
  output logic full,
  output logic near_drained_flag,
  output logic near_filled_flag,
  output logic irq,
  input wire logic [DCF_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [DCF_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  typedef struct packed {
    logic [DCF_DEPTH-1:0] mem;
    logic [DCF_PTR_W-1:0] wptr;
    logic [DCF_PTR_W-1:0] rptr;
    logic empty;
    logic full;
    logic ae;
    logic af;
    logic [2:0] wcode;
    logic [2:0] rcode;
    logic pipe;
    logic [DCF_THR_W-1:0] near_drained_threshold;
    logic [DCF_THR_W-1:0] near_filled_threshold;
    logic [DATA_W-1:0] stage;
    logic stage_vld;
    logic [DATA_W-1:0] rdata;
    logic [DCF_EV_W-1:0] ist;
    logic [DCF_EV_W-1:0] ien;
    logic irq;
    logic aw_ok;
    logic [DCF_ADDR_W-1:0] awaddr;
    logic w_ok;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] axi_rdata;
    logic [1:0] rresp;
  } dcf_state_t;

  dcf_state_t q;
  dcf_state_t d;

  logic [DCF_PTR_W-1:0] ww;
  logic [DCF_PTR_W-1:0] rw;
  logic wr_go;
  logic rd_go;
  logic [DCF_AW-1:0] widx;
  logic [DCF_AW-1:0] ridx;
  logic [DATA_W-1:0] fresh;
  logic [DCF_PTR_W-1:0] lvl;
  logic [DCF_PTR_W-1:0] lvl_r;
  logic [DCF_PTR_W-1:0] lvl_w;
  logic [DCF_EV_W-1:0] ev;
  logic [DCF_EV_W-1:0] clr;
  logic [31:0] wr_val;

  // Width code to bit count; illegal codes fold to the widest port
  function automatic logic [DCF_PTR_W-1:0] width_of(input logic [2:0] code);
    logic [2:0] c;
    c = (code > DCF_CODE_MAX) ? DCF_CODE_MAX : code;
    return DCF_PTR_W'(1) << c;
  endfunction

  // Byte-lane merge of a write onto the old register value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Fill the next state: bus slave, FIFO moves, flags and interrupts
  always_comb
  begin
    d = q;
    clr = '0;
    ev = '0;
    wr_val = '0;
    fresh = '0;
    widx = '0;
    ridx = '0;
    ww = width_of(q.wcode);
    rw = width_of(q.rcode);

    // Write address and data are taken in either order
    if (s_axi_awvalid && q.awready)
    begin
      d.aw_ok = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready)
    begin
      d.w_ok = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready)
    begin
      d.bvalid = 1'b0;
    end
    // Register write once both halves are held and no response is pending
    if (d.aw_ok && d.w_ok && !q.bvalid)
    begin
      d.aw_ok = 1'b0;
      d.w_ok = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = DCF_RESP_OKAY;
      unique case (d.awaddr)
        DCF_OFF_CTRL:
        begin
          wr_val = merge({23'h0, q.pipe, 1'b0, q.rcode, 1'b0, q.wcode}, d.wdata, d.wstrb);
          d.wcode = wr_val[DCF_CTRL_WCODE +: 3];
          d.rcode = wr_val[DCF_CTRL_RCODE +: 3];
          d.pipe = wr_val[DCF_CTRL_PIPE];
        end
        DCF_OFF_AE_THR:
        begin
          wr_val = merge({20'h0, q.near_drained_threshold}, d.wdata, d.wstrb);
          d.near_drained_threshold = wr_val[DCF_THR_W-1:0];
        end
        DCF_OFF_AF_THR:
        begin
          wr_val = merge({20'h0, q.near_filled_threshold}, d.wdata, d.wstrb);
          d.near_filled_threshold = wr_val[DCF_THR_W-1:0];
        end
        DCF_OFF_IRQ_EN:
        begin
          wr_val = merge({28'h0, q.ien}, d.wdata, d.wstrb);
          d.ien = wr_val[DCF_EV_W-1:0];
        end
        DCF_OFF_IRQ_CLR:
        begin
          wr_val = merge(32'h0, d.wdata, d.wstrb);
          clr = wr_val[DCF_EV_W-1:0];
        end
        // Status is read-only; a write there is accepted and dropped
        DCF_OFF_STATUS, DCF_OFF_IRQ_STAT:
        begin
          d.bresp = DCF_RESP_OKAY;
        end
        default:
        begin
          d.bresp = DCF_RESP_SLVERR;
        end
      endcase
    end
    d.awready = !d.aw_ok;
    d.wready = !d.w_ok;

    // Read channel: one read in flight, answered the cycle after address
    if (q.rvalid && s_axi_rready)
    begin
      d.rvalid = 1'b0;
      d.arready = 1'b1;
    end
    if (s_axi_arvalid && q.arready)
    begin
      d.arready = 1'b0;
      d.rvalid = 1'b1;
      d.rresp = DCF_RESP_OKAY;
      unique case (s_axi_araddr)
        DCF_OFF_CTRL:
          d.axi_rdata = {23'h0, q.pipe, 1'b0, q.rcode, 1'b0, q.wcode};
        DCF_OFF_AE_THR:
          d.axi_rdata = {20'h0, q.near_drained_threshold};
        DCF_OFF_AF_THR:
          d.axi_rdata = {20'h0, q.near_filled_threshold};
        DCF_OFF_STATUS:
          d.axi_rdata = {3'h0, q.wptr - q.rptr, 12'h0, q.af, q.ae, q.full, q.empty};
        DCF_OFF_IRQ_STAT:
          d.axi_rdata = {28'h0, q.ist};
        DCF_OFF_IRQ_EN:
          d.axi_rdata = {28'h0, q.ien};
        DCF_OFF_IRQ_CLR:
          d.axi_rdata = 32'h0;
        default:
        begin
          d.axi_rdata = 32'h0;
          d.rresp = DCF_RESP_SLVERR;
        end
      endcase
    end

    // A port move happens only when its flag allows a whole word
    wr_go = write_en && block_select_in && !q.full;
    rd_go = read_en && block_select_in && !q.empty;
    ev[DCF_EV_WR_REFUSED] = write_en && block_select_in && q.full;
    ev[DCF_EV_RD_REFUSED] = read_en && block_select_in && q.empty;

    // Bit-serial addressing lets any width pair share one storage ring
    for (int i = 0; i < DATA_W; i++)
    begin
      widx = q.wptr[DCF_AW-1:0] + DCF_AW'(i);
      ridx = q.rptr[DCF_AW-1:0] + DCF_AW'(i);
      if (wr_go && (DCF_PTR_W'(i) < ww))
      begin
        d.mem[widx] = write_data_in[i];
      end
      fresh[i] = (DCF_PTR_W'(i) < rw) ? q.mem[ridx] : 1'b0;
    end
    if (wr_go)
    begin
      d.wptr = q.wptr + ww;
    end
    if (rd_go)
    begin
      d.rptr = q.rptr + rw;
    end

    // Flow-through shows the word at the read edge; pipelined one edge later
    d.stage_vld = rd_go && q.pipe;
    if (rd_go)
    begin
      d.stage = fresh;
    end
    if (rd_go && !q.pipe)
    begin
      d.rdata = fresh;
    end
    else if (q.stage_vld)
    begin
      d.rdata = q.stage;
    end

    // Flags follow the pointers after this edge, with no extra latency
    lvl = d.wptr - d.rptr;
    d.empty = lvl < rw;
    d.full = (DCF_DEPTH_BITS - lvl) < ww;
    // Only whole words count toward the almost thresholds
    lvl_r = lvl & ~(rw - DCF_PTR_W'(1));
    lvl_w = lvl & ~(ww - DCF_PTR_W'(1));
    // Thresholds are bit positions, so 8/16-bit users scale by 8/16
    if (q.ae)
    begin
      d.ae = !(lvl_r > {1'b0, q.near_drained_threshold});
    end
    else
    begin
      d.ae = lvl_r <= {1'b0, q.near_drained_threshold};
    end
    if (q.af)
    begin
      d.af = !(lvl_w < {1'b0, q.near_filled_threshold});
    end
    else
    begin
      d.af = lvl_w >= {1'b0, q.near_filled_threshold};
    end
    ev[DCF_EV_AE_RISE] = d.ae && !q.ae;
    ev[DCF_EV_AF_RISE] = d.af && !q.af;

    // Sticky status: an event in the clearing cycle survives the clear
    d.ist = (q.ist & ~clr) | ev;
    d.irq = |(d.ist & d.ien);
  end

  // One state register; reset empties the FIFO and drops read data
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q <= '0;
      q.empty <= 1'b1;
      q.ae <= 1'b1;
      q.wcode <= DCF_RST_WCODE;
      q.rcode <= DCF_RST_RCODE;
      q.near_drained_threshold <= DCF_RST_AE_THR;
      q.near_filled_threshold <= DCF_RST_AF_THR;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  // Every output is a bit of the state register
  assign read_data = q.rdata;
  assign empty = q.empty;
  assign full = q.full;
  assign near_drained_flag = q.ae;
  assign near_filled_flag = q.af;
  assign irq = q.irq;
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bresp = q.bresp;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_arready = q.arready;
  assign s_axi_rdata = q.axi_rdata;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rvalid = q.rvalid;

endmodule // dcf_fifo_flags

`default_nettype wire

// ===== testbench/dcf_fifo_flags_assertions.sv
// Port-level assertions for the FIFO flag block
`timescale 1ns/1ps
`default_nettype none
module dcf_flag_checker
  import dcf_pkg::*;
#(parameter int DATA_W = DCF_MAX_W)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic write_en,
  input wire logic read_en,
  input wire logic block_select_in,
  input wire logic [DATA_W-1:0] read_data,
  input wire logic empty,
  input wire logic full,
  input wire logic near_drained_flag,
  input wire logic near_filled_flag
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Requests that count; a deselected port moves nothing
  wire logic wr = write_en && block_select_in;
  wire logic rd = read_en && block_select_in;
  // Two cycles with no read, enough for the pipelined word to land
  sequence s_no_rd2;
    !rd ##1 !rd;
  endsequence
  a_reset_state:
    assert property (disable iff (1'b0) !aresetn |=> read_data == '0 && empty && !full
      && near_drained_flag && !near_filled_flag) else $error("reset state wrong");
  a_full_refuse:
    assert property (full && wr && !rd |=> full) else $error("write taken while full");
  a_empty_refuse:
    assert property (empty && rd && !wr |=> empty) else $error("read taken while empty");
  a_empty_rise:
    assert property ($past(aresetn) && $rose(empty) |-> $past(rd)) else $error("empty rose");
  a_full_rise:
    assert property ($past(aresetn) && $rose(full) |-> $past(wr)) else $error("full rose");
  a_empty_fall:
    assert property ($past(aresetn) && $fell(empty) |-> $past(wr)) else $error("empty fell");
  a_full_fall:
    assert property ($past(aresetn) && $fell(full) |-> $past(rd)) else $error("full fell");
  a_rdata_hold:
    assert property (s_no_rd2 |=> $stable(read_data)) else $error("read data moved");
endmodule // dcf_flag_checker
bind dcf_fifo_flags dcf_flag_checker #(.DATA_W(DATA_W)) u_chk (.*);
`default_nettype wire

// ===== testbench/dcf_fabric_model.sv
// Fabric-side driver of the FIFO ports
`timescale 1ns/1ps
`default_nettype none
module dcf_fabric_model
  import dcf_pkg::*;
(
  input wire logic aclk,
  input wire logic wr_go,
  input wire logic rd_go,
  input wire logic hold_off,
  input wire logic [DCF_MAX_W-1:0] wr_word,
  output logic write_en = 1'b0,
  output logic read_en = 1'b0,
  output logic block_select_in = 1'b1,
  output logic [DCF_MAX_W-1:0] write_data_in = 16'h0
);
  // Idle data is inverted so a stale word never passes for a fresh one
  always @(posedge aclk)
  begin
    write_en <= wr_go;
    read_en <= rd_go;
    block_select_in <= !hold_off;
    write_data_in <= wr_go ? wr_word : ~write_data_in;
  end
endmodule // dcf_fabric_model
`default_nettype wire

// ===== testbench/dual_clock_fifo_flag_logic_test.sv
// Self-checking bench for the FIFO flag block
`timescale 1ns/1ps
`default_nettype none
module dual_clock_fifo_flag_logic_test
  import dcf_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0, wr_go = 1'b0, rd_go = 1'b0, hold_off = 1'b0;
  logic [15:0] wr_word = 16'h0, write_data_in, read_data;
  logic write_en, read_en, block_select_in, empty, full, irq;
  logic near_drained_flag, near_filled_flag;
  logic [15:0] ra, rb;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int fail_count = 0, checked = 0, cyc = 0;
  wire logic [31:0] flg = {27'h0, irq, empty, full, near_drained_flag, near_filled_flag};
  dcf_fifo_flags dut (.*, .s_axi_wstrb(4'hf));
  dcf_fabric_model u_fab (.*);
  initial forever #2.5 aclk = ~aclk;
  // Hang guard: far above the longest fill
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fail_count++;
      wrap_up;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %0t %s got %h", $time, m, got);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic rst;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
  endtask
  // Fabric moves: n request cycles, then let flags settle
  task automatic fab(input logic w, input logic r, input int n, input logic [15:0] d);
    @(posedge aclk);
    wr_go <= w;
    rd_go <= r;
    wr_word <= d;
    repeat (n) @(posedge aclk);
    wr_go <= 1'b0;
    rd_go <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask
  // Timed read: a is read data one cycle after the read edge, b two cycles after
  task automatic rdt(output logic [15:0] a, output logic [15:0] b);
    @(posedge aclk);
    rd_go <= 1'b1;
    @(posedge aclk);
    rd_go <= 1'b0;
    repeat (2) @(posedge aclk);
    a = read_data;
    @(posedge aclk);
    b = read_data;
    repeat (2) @(posedge aclk);
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic e);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, e ? {30'h0, DCF_RESP_SLVERR} : 32'h0, "bresp");
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] x, input logic e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, x, "rdata");
    chk({30'h0, s_axi_rresp}, e ? {30'h0, DCF_RESP_SLVERR} : 32'h0, "rresp");
  endtask
  // Flag word: irq, empty, full, near drained, near filled
  initial
  begin
    rst;
    axw(DCF_OFF_CTRL, 32'h21, 1'b0);
    fab(1'b1, 1'b0, 1, 16'h1);
    chk(flg, 32'ha, "half word");
    fab(1'b1, 1'b0, 1, 16'h2);
    chk(flg, 32'h2, "whole word");
    fab(1'b0, 1'b1, 1, 16'h0);
    chk({16'h0, read_data}, 32'h9, "packed word");
    fab(1'b0, 1'b1, 1, 16'h0);
    chk(flg, 32'ha, "read when empty");
    $display("narrow write test done");
    rst;
    chk({16'h0, read_data}, 32'h0, "data reset");
    chk(flg, 32'ha, "flag reset");
    axr(DCF_OFF_CTRL, 32'h33, 1'b0);
    axr(DCF_OFF_AE_THR, 32'h10, 1'b0);
    axr(DCF_OFF_AF_THR, 32'hff0, 1'b0);
    axr(8'h1c, 32'h0, 1'b1);
    axw(8'h1c, 32'h1, 1'b1);
    $display("reset test done");
    axw(DCF_OFF_CTRL, 32'h12, 1'b0);
    axw(DCF_OFF_IRQ_EN, 32'h1, 1'b0);
    fab(1'b1, 1'b0, 1024, 16'ha5a5);
    chk(flg, 32'h5, "filled");
    fab(1'b1, 1'b0, 1, 16'h3);
    chk(flg, 32'h15, "refused write");
    axr(DCF_OFF_IRQ_STAT, 32'h9, 1'b0);
    axw(DCF_OFF_IRQ_CLR, 32'h1, 1'b0);
    chk(flg, 32'h5, "irq cleared");
    fab(1'b0, 1'b1, 1, 16'h0);
    chk(flg, 32'h5, "full after one read");
    fab(1'b0, 1'b1, 1, 16'h0);
    chk(flg, 32'h1, "room for a word");
    $display("wide write test done");
    rst;
    hold_off <= 1'b1;
    fab(1'b1, 1'b0, 1, 16'h7);
    chk(flg, 32'ha, "deselected");
    hold_off <= 1'b0;
    axw(DCF_OFF_AE_THR, 32'hffff_f0c8, 1'b0);
    axr(DCF_OFF_AE_THR, 32'hc8, 1'b0);
    fab(1'b1, 1'b0, 25, 16'h5a);
    chk(flg, 32'h2, "at threshold");
    fab(1'b1, 1'b0, 1, 16'h5b);
    chk(flg, 32'h0, "above threshold");
    fab(1'b0, 1'b1, 1, 16'h0);
    chk(flg, 32'h2, "back at threshold");
    $display("threshold test done");
    rst;
    axw(DCF_OFF_CTRL, 32'h77, 1'b0);
    fab(1'b1, 1'b0, 1, 16'hbeef);
    fab(1'b1, 1'b0, 1, 16'h1234);
    rdt(ra, rb);
    chk({16'h0, ra}, 32'hbeef, "flow-through word");
    axw(DCF_OFF_CTRL, 32'h144, 1'b0);
    rdt(ra, rb);
    chk({16'h0, ra}, 32'hbeef, "pipelined early");
    chk({16'h0, rb}, 32'h1234, "pipelined word");
    chk(flg, 32'ha, "wide drained");
    rst;
    chk({16'h0, read_data}, 32'h0, "pipelined reset");
    $display("read mode test done");
    wrap_up;
  end
endmodule // dual_clock_fifo_flag_logic_test
`default_nettype wire
